// ---- fall_detect.sv ----
// Purpose: Falling-edge detector for the external trigger input
// Assumes: Input already synchronous to ref_clk
// Notes:   One-cycle pulse per high-to-low transition
`timescale 1ns/1ps
`default_nettype none
module fall_detect (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic level_in,
    output logic      fall
);
    import trig_pkg::*;

    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = level_in;
    end

    // Idle-high reset, so a line held low at release reads as an edge
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= EXT_IDLE_LEVEL;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign fall = prev_q & ~level_in;

endmodule // fall_detect
`default_nettype wire

// ---- far_side_model.sv ----
// Purpose: Reading engine stand-in answering each request
// Assumes: One request outstanding at a time
// Notes:   A lag of 1 is the fastest legal answer
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       reading_start,
    input  wire logic [3:0] lag,
    output logic            reading_done
);
    logic [3:0] wait_q;
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn) wait_q <= 4'h0;
        else if (reading_start) wait_q <= lag;
        else if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
    assign reading_done = (wait_q == 4'h1);
endmodule // far_side_model
`default_nettype wire

// ---- measurement_trigger_controller.sv ----
// Purpose: Trigger source selection, arming, set-up blanking and counting
// Assumes: Commands arrive as one-cycle pulses in a cmd_s bundle
// Notes:   Reading engine is outside; it answers reading_start with reading_done
`timescale 1ns/1ps
`default_nettype none
module measurement_trigger_controller #(
    parameter int SETUP_CYCLES = trig_pkg::SETUP_CYCLES
) (
    input  wire logic            ref_clk,
    input  wire logic            rstn,
    input  wire trig_pkg::cmd_s  cmd,
    input  wire logic            ext_trig_n,
    input  wire logic            reading_done,
    output logic                 reading_start,
    output logic                 measurement_done_output,
    output logic                 settings_conflict,
    output logic                 bus_trg_rejected,
    output logic                 trigger_ignored,
    output trig_pkg::status_s    status
);
    import trig_pkg::*;

    localparam int TW = (SETUP_CYCLES > 1) ? $clog2(SETUP_CYCLES) : 1;

    // Refused at elaboration: a zero-length set-up has no timer value
    if (SETUP_CYCLES < 1) begin : g_bad_setup
        $error("SETUP_CYCLES must be at least 1");
    end

    trig_state_e         state_q,     state_d;
    trig_src_e           src_q,       src_d;
    logic [COUNT_W-1:0]  tcount_q,    tcount_d;
    logic [COUNT_W-1:0]  scount_q,    scount_d;
    logic [COUNT_W-1:0]  taken_q,     taken_d;
    logic [COUNT_W-1:0]  left_q,      left_d;
    logic [TW-1:0]       timer_q,     timer_d;
    logic                one_shot_q,  one_shot_d;
    logic                done_q,      done_d;
    logic                conflict_q,  conflict_d;
    logic                rejected_q,  rejected_d;
    logic                ignored_q,   ignored_d;

    logic                ext_fall;
    logic                trig_seen;
    logic                trig_hit;
    logic                in_idle;
    logic                arm_req;

    fall_detect u_fall (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .level_in (ext_trig_n),
        .fall     (ext_fall)
    );

    assign in_idle = (state_q == st_idle);
    assign arm_req = cmd.arm | cmd.read_query;

    // Any trigger event of the selected source, regardless of state
    always_comb begin
        case (src_q)
            src_imm: trig_seen = 1'b1;
            src_ext: trig_seen = ext_fall;
            src_bus: trig_seen = cmd.bus_trg | cmd.bus_get;
            default: trig_seen = 1'b0;
        endcase
    end

    assign trig_hit = trig_seen & (state_q == st_wait);

    always_comb begin
        state_d    = state_q;
        src_d      = src_q;
        tcount_d   = tcount_q;
        scount_d   = scount_q;
        taken_d    = taken_q;
        left_d     = left_q;
        timer_d    = timer_q;
        one_shot_d = one_shot_q;
        done_d     = 1'b0;
        conflict_d = 1'b0;
        rejected_d = 1'b0;
        ignored_d  = 1'b0;

        // Configuration writes are only taken in idle
        if (cmd.set_source) begin
            if (in_idle) begin
                src_d = cmd.source;
            end else begin
                conflict_d = 1'b1;
            end
        end

        if (cmd.set_count && in_idle) begin
            if (cmd.count_min) begin
                tcount_d = TRIG_COUNT_MIN;
            end else if (cmd.count_max) begin
                tcount_d = TRIG_COUNT_MAX;
            end else if (cmd.count_value < TRIG_COUNT_MIN) begin
                tcount_d = TRIG_COUNT_MIN;
            end else if (cmd.count_value > TRIG_COUNT_MAX) begin
                tcount_d = TRIG_COUNT_MAX;
            end else begin
                tcount_d = cmd.count_value;
            end
        end

        if (cmd.set_samples && in_idle) begin
            scount_d = (cmd.sample_value < SAMPLE_COUNT_MIN) ? SAMPLE_COUNT_MIN
                                                             : cmd.sample_value;
        end

        // Bus trigger command outside waiting is refused when the bus is the selected source
        if (src_q == src_bus && cmd.bus_trg && state_q != st_wait) begin
            rejected_d = 1'b1;
        end

        // Non-immediate triggers that miss the window, set-up included; bus_trg is flagged as rejected instead
        if (src_q != src_imm && trig_seen && state_q != st_wait) begin
            ignored_d = ~(cmd.bus_trg & (src_q == src_bus));
        end

        case (state_q)
            st_idle: begin
                if (cmd.measure_query) begin
                    src_d      = src_imm;
                    tcount_d   = TRIG_COUNT_RESET;
                    one_shot_d = 1'b1;
                    left_d     = 16'h0001;
                    taken_d    = '0;
                    state_d    = st_start;
                end else if (cmd.configure) begin
                    src_d    = src_imm;
                    tcount_d = TRIG_COUNT_RESET;
                end else if (arm_req) begin
                    one_shot_d = 1'b0;
                    taken_d    = '0;
                    timer_d    = TW'(SETUP_CYCLES - 1);
                    state_d    = st_setup;
                end
            end
            st_setup: begin
                // Triggers here fall through the ignore path above
                if (timer_q == '0) begin
                    state_d = st_wait;
                end else begin
                    timer_d = timer_q - 1'b1;
                end
            end
            st_wait: begin
                if (trig_hit) begin
                    left_d  = scount_q;
                    state_d = st_start;
                end
            end
            st_start: begin
                state_d = st_busy;
            end
            st_busy: begin
                if (reading_done) begin
                    done_d = 1'b1;
                    if (left_q > 16'h0001) begin
                        left_d  = left_q - 16'h0001;
                        state_d = st_start;
                    end else begin
                        taken_d = taken_q + 16'h0001;
                        // Count compared before increment lands
                        if (one_shot_q || (taken_q + 16'h0001) >= tcount_q) begin
                            state_d = st_idle;
                        end else begin
                            state_d = st_wait;
                        end
                    end
                end
            end
            default: begin
                state_d = st_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= st_idle;
            src_q      <= src_imm;
            tcount_q   <= TRIG_COUNT_RESET;
            scount_q   <= SAMPLE_COUNT_RESET;
            taken_q    <= '0;
            left_q     <= '0;
            timer_q    <= '0;
            one_shot_q <= 1'b0;
            done_q     <= 1'b0;
            conflict_q <= 1'b0;
            rejected_q <= 1'b0;
            ignored_q  <= 1'b0;
        end else begin
            state_q    <= state_d;
            src_q      <= src_d;
            tcount_q   <= tcount_d;
            scount_q   <= scount_d;
            taken_q    <= taken_d;
            left_q     <= left_d;
            timer_q    <= timer_d;
            one_shot_q <= one_shot_d;
            done_q     <= done_d;
            conflict_q <= conflict_d;
            rejected_q <= rejected_d;
            ignored_q  <= ignored_d;
        end
    end

    // Handshake output, decoded from state
    assign reading_start           = (state_q == st_start);
    assign measurement_done_output = done_q;
    assign settings_conflict       = conflict_q;
    assign bus_trg_rejected        = rejected_q;
    assign trigger_ignored         = ignored_q;

    always_comb begin
        status.idle         = (state_q == st_idle);
        status.setup        = (state_q == st_setup);
        status.waiting      = (state_q == st_wait);
        status.measuring    = (state_q == st_start) || (state_q == st_busy);
        status.source       = src_q;
        status.trig_count   = tcount_q;
        status.sample_count = scount_q;
        status.trigs_taken  = taken_q;
    end

endmodule // measurement_trigger_controller
`default_nettype wire

// ---- mtc_sva.sv ----
// Purpose: Port-level checks for the trigger controller
// Assumes: Status fields decode the state register directly
// Notes:   Bound to every controller instance
`timescale 1ns/1ps
`default_nettype none
module mtc_sva #(
    parameter int SETUP_CYCLES = trig_pkg::SETUP_CYCLES
) (
    input wire logic              ref_clk,
    input wire logic              rstn,
    input wire trig_pkg::cmd_s    cmd,
    input wire logic              ext_trig_n,
    input wire logic              reading_done,
    input wire logic              reading_start,
    input wire logic              measurement_done_output,
    input wire logic              settings_conflict,
    input wire logic              bus_trg_rejected,
    input wire logic              trigger_ignored,
    input wire trig_pkg::status_s status
);
    import trig_pkg::*;
    int setup_cnt_q;
    // Counter, not repetition: real set-up spans millions of cycles
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn) setup_cnt_q <= 0;
        else setup_cnt_q <= status.setup ? setup_cnt_q + 1 : 0;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_done_cause: assert property (measurement_done_output |-> $past(reading_done))
        else $error("done pulse without finished reading");
    a_start_single: assert property (reading_start |=> !reading_start)
        else $error("reading request longer than one cycle");
    a_setup_len: assert property ($fell(status.setup) |-> setup_cnt_q == SETUP_CYCLES)
        else $error("set-up interval has wrong length");
    a_setup_quiet: assert property (status.setup |-> !reading_start)
        else $error("reading during set-up");
    a_ext_ignored: assert property (status.source == src_ext && status.setup
        && $fell(ext_trig_n) |-> ##[1:2] trigger_ignored)
        else $error("edge in set-up not flagged");
    a_src_conflict: assert property (cmd.set_source && !status.idle
        |=> settings_conflict && status.source == $past(status.source))
        else $error("source change outside idle not refused");
    a_bus_reject: assert property (cmd.bus_trg && status.source == src_bus
        && !status.waiting |=> bus_trg_rejected)
        else $error("bus trigger outside wait not rejected");
    a_one_shot_measure_query_once: assert property (cmd.measure_query && status.idle
        |=> reading_start && status.source == src_imm
        && status.trig_count == TRIG_COUNT_RESET)
        else $error("measure query did not start at once");
    a_idle_quiet: assert property (status.idle && !cmd.measure_query |=> !reading_start)
        else $error("reading started from idle");
    a_count_max: assert property (cmd.set_count && cmd.count_max && !cmd.count_min
        && status.idle |=> status.trig_count == TRIG_COUNT_MAX)
        else $error("max keyword stored wrong count");
    a_imm_start: assert property (status.waiting && status.source == src_imm
        |=> reading_start)
        else $error("armed immediate source did not start");
    a_ext_hit: assert property (status.waiting && status.source == src_ext
        && $fell(ext_trig_n) |=> reading_start)
        else $error("external edge in wait did not start a reading");
    c_setup: cover property ($fell(status.setup));
    c_conflict: cover property (settings_conflict);
    c_reject: cover property (bus_trg_rejected);
endmodule // mtc_sva
bind measurement_trigger_controller mtc_sva #(.SETUP_CYCLES(SETUP_CYCLES)) i_mtc_sva (
    .ref_clk(ref_clk), .rstn(rstn), .cmd(cmd), .ext_trig_n(ext_trig_n),
    .reading_done(reading_done), .reading_start(reading_start),
    .measurement_done_output(measurement_done_output), .settings_conflict(settings_conflict),
    .bus_trg_rejected(bus_trg_rejected), .trigger_ignored(trigger_ignored), .status(status));
`default_nettype wire

// ---- test_measurement_trigger_controller.sv ----
// Purpose: Directed test of arming, sources and counts
// Assumes: Set-up shortened to eight cycles
// Notes:   Commands go in as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module test_measurement_trigger_controller;
    import trig_pkg::*;
    logic        ref_clk, rstn, ext_trig_n, rd_done, rd_start, done, conf, rej, ign;
    logic [3:0]  lag;
    cmd_s        cmd;
    status_s     st;
    int          err_count = 0, checks = 0;
    logic [15:0] n_done = '0, n_start = '0, n_ign = '0, n_conf = '0, n_rej = '0;
    measurement_trigger_controller #(.SETUP_CYCLES(8)) i_measurement_trigger_controller (
        .ref_clk(ref_clk), .rstn(rstn), .cmd(cmd), .ext_trig_n(ext_trig_n),
        .reading_done(rd_done), .reading_start(rd_start), .measurement_done_output(done),
        .settings_conflict(conf), .bus_trg_rejected(rej), .trigger_ignored(ign), .status(st));
    far_side_model i_far_side_model (.ref_clk(ref_clk), .rstn(rstn),
        .reading_start(rd_start), .lag(lag), .reading_done(rd_done));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        n_done  <= n_done + {15'h0, done};
        n_start <= n_start + {15'h0, rd_start};
        n_ign   <= n_ign + {15'h0, ign};
        n_conf  <= n_conf + {15'h0, conf};
        n_rej   <= n_rej + {15'h0, rej};
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Codes: 0 arm 1 read 2 measure 3 configure 4 trg 5 get 6 source 7 samples
    // Codes: 8 count 9 min 10 max 11 external pulse
    task automatic op(input int k, input logic [15:0] v);
        cmd_s c;
        c = '0;
        c.source = trig_src_e'(v[1:0]);
        c.count_value = v;
        c.sample_value = v;
        c.set_count = (k >= 8 && k <= 10);
        c.count_min = (k == 9);
        c.count_max = (k == 10);
        {c.arm, c.read_query, c.measure_query, c.configure, c.bus_trg, c.bus_get,
            c.set_source, c.set_samples} = 8'h80 >> k;
        tick(1);
        cmd = c;
        ext_trig_n = (k != 11);
        tick(1);
        cmd = '0;
        ext_trig_n = 1'b1;
    endtask
    // Zero waits for the wait state, else for n finished readings
    task automatic wait_for(input logic [15:0] n);
        int i;
        for (i = 0; i < 300 && !(n == 16'h0 ? st.waiting === 1'b1 : n_done === n); i++)
            tick(1);
        if (i == 300) err_count++;
        tick(2);
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #300000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        rstn = 1'b0;
        ext_trig_n = 1'b1;
        lag = 4'h1;
        cmd = '0;
        tick(16);
        rstn = 1'b1;
        check("idle", {15'h0, st.idle}, 16'h1);
        check("count", st.trig_count, 16'h1);
        check("source", {14'h0, st.source}, 16'h0);
        op(6, 16'h1);
        op(8, 16'h5);
        op(7, 16'h3);
        check("samples", st.sample_count, 16'h3);
        op(2, 16'h0);
        check("one_shot_measure_query_busy", {15'h0, st.measuring}, 16'h1);
        wait_for(16'h1);
        check("one_shot_measure_query_starts", n_start, 16'h1);
        check("one_shot_measure_query_source", {14'h0, st.source}, 16'h0);
        check("one_shot_measure_query_count", st.trig_count, 16'h1);
        op(10, 16'h0);
        check("count_max", st.trig_count, 16'hc350);
        op(9, 16'h0);
        check("count_min", st.trig_count, 16'h1);
        op(8, 16'h0);
        check("count_low", st.trig_count, 16'h1);
        op(8, 16'hffff);
        check("count_clamp", st.trig_count, 16'hc350);
        op(8, 16'h2);
        op(7, 16'h2);
        op(6, 16'h1);
        op(1, 16'h0);
        check("setup_on", {15'h0, st.setup}, 16'h1);
        op(11, 16'h0);
        op(6, 16'h2);
        wait_for(16'h0);
        check("setup_ign", n_ign, 16'h1);
        check("setup_starts", n_start, 16'h1);
        check("conflict", n_conf, 16'h1);
        check("kept_source", {14'h0, st.source}, 16'h1);
        op(11, 16'h0);
        wait_for(16'h3);
        op(11, 16'h0);
        wait_for(16'h5);
        check("ext_starts", n_start, 16'h5);
        check("ext_idle", {15'h0, st.idle}, 16'h1);
        check("ext_taken", st.trigs_taken, 16'h2);
        op(11, 16'h0);
        tick(2);
        check("idle_ign", n_ign, 16'h2);
        op(7, 16'h0);
        check("samples_min", st.sample_count, 16'h1);
        op(6, 16'h2);
        op(4, 16'h0);
        tick(1);
        check("trg_idle", n_rej, 16'h1);
        op(0, 16'h0);
        wait_for(16'h0);
        check("armed", {15'h0, st.waiting}, 16'h1);
        op(6, 16'h1);
        op(4, 16'h0);
        wait_for(16'h6);
        check("wait_conflict", n_conf, 16'h2);
        check("wait_source", {14'h0, st.source}, 16'h2);
        op(5, 16'h0);
        wait_for(16'h7);
        check("bus_starts", n_start, 16'h7);
        check("bus_rej", n_rej, 16'h1);
        check("bus_idle", {15'h0, st.idle}, 16'h1);
        op(8, 16'h3);
        op(3, 16'h0);
        check("conf_count", st.trig_count, 16'h1);
        check("conf_source", {14'h0, st.source}, 16'h0);
        op(7, 16'h2);
        lag = 4'h5;
        op(0, 16'h0);
        wait_for(16'h9);
        check("imm_starts", n_start, 16'h9);
        check("imm_taken", st.trigs_taken, 16'h1);
        check("done_total", n_done, 16'h9);
        tally_and_finish();
    end
endmodule // test_measurement_trigger_controller
`default_nettype wire

// ---- trig_pkg.sv ----
// Purpose: Shared constants, modes and carriers for the trigger controller
// Assumes: 100 MHz ref_clk
// Notes:   Command and status bundles travel as packed structs
package trig_pkg;

    localparam int CLK_FREQ_HZ    = 100_000_000;
    localparam int SETUP_TIME_MS  = 20;
    // Set-up time after arming, in clock cycles
    localparam int SETUP_CYCLES   = SETUP_TIME_MS * (CLK_FREQ_HZ / 1000);

    localparam int COUNT_W        = 16;
    localparam logic [COUNT_W-1:0] TRIG_COUNT_MIN     = 16'h0001;
    localparam logic [COUNT_W-1:0] TRIG_COUNT_MAX     = 16'hc350;
    localparam logic [COUNT_W-1:0] TRIG_COUNT_RESET   = 16'h0001;
    localparam logic [COUNT_W-1:0] SAMPLE_COUNT_MIN   = 16'h0001;
    localparam logic [COUNT_W-1:0] SAMPLE_COUNT_RESET = 16'h0001;
    localparam logic               EXT_IDLE_LEVEL     = 1'b1;

    typedef enum logic [1:0] {
        src_imm,
        src_ext,
        src_bus
    } trig_src_e;

    typedef enum logic [2:0] {
        st_idle,
        st_setup,
        st_wait,
        st_start,
        st_busy
    } trig_state_e;

    typedef struct packed {
        logic                arm;
        logic                read_query;
        logic                measure_query;
        logic                configure;
        logic                set_source;
        trig_src_e           source;
        logic                set_count;
        logic                count_min;
        logic                count_max;
        logic [COUNT_W-1:0]  count_value;
        logic                set_samples;
        logic [COUNT_W-1:0]  sample_value;
        logic                bus_trg;
        logic                bus_get;
    } cmd_s;

    typedef struct packed {
        logic                idle;
        logic                setup;
        logic                waiting;
        logic                measuring;
        trig_src_e           source;
        logic [COUNT_W-1:0]  trig_count;
        logic [COUNT_W-1:0]  sample_count;
        logic [COUNT_W-1:0]  trigs_taken;
    } status_s;

endpackage
